// File: core/fsu_fifo.sv
// Byte FIFO of 64 entries that can shrink to a single holding register
`timescale 1ns/1ps
`include "fsu_map.svh"
module fsu_fifo (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic flush,
  input wire logic one_deep,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  // Fill level
  output logic [6:0] level
);
  import fsu_pkg::*;
  fsu_fifo_st_t st_reg; // Storage and pointers
  fsu_fifo_st_t st_next; // Next value
  // Capacity is one entry in legacy mode
  assign in_ready = st_reg.cnt < (one_deep ? 7'h01 : `FSU_FIFO_DEPTH);
  assign out_valid = st_reg.cnt != 7'h00;
  assign out_data = st_reg.mem[st_reg.rp];
  assign level = st_reg.cnt;
  // Push, pop and flush
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = st_reg.wp + 6'h01;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 6'h01;
    end
    st_next.cnt = st_reg.cnt + {6'h00, push} - {6'h00, pop};
    // Flush wins over a push in the same cycle
    if (flush) begin
      st_next.wp = 6'h00;
      st_next.rp = 6'h00;
      st_next.cnt = 7'h00;
    end
  end
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : fsu_fifo

// File: core/fsu_map.svh
// Register offsets, field positions, reset values and counts of the serial port core
`ifndef FSU_MAP_SVH
`define FSU_MAP_SVH
// Register byte offsets
`define FSU_OFF_DATA 8'h00
`define FSU_OFF_IER 8'h04
`define FSU_OFF_IIR 8'h08
`define FSU_OFF_LCR 8'h0C
`define FSU_OFF_MCR 8'h10
`define FSU_OFF_LSR 8'h14
`define FSU_OFF_MSR 8'h18
`define FSU_OFF_SCR 8'h1C
`define FSU_OFF_ISR 8'h20
`define FSU_OFF_IMR 8'h24
// Line control fields
`define FSU_LCR_STB 2
`define FSU_LCR_PEN 3
`define FSU_LCR_EPS 4
`define FSU_LCR_STK 5
`define FSU_LCR_BRK 6
`define FSU_LCR_DLAB 7
// Modem control fields
`define FSU_MCR_LOOP 4
`define FSU_MCR_AFC 5
`define FSU_MCR_SIR 6
// FIFO control fields
`define FSU_FCR_EN 0
`define FSU_FCR_RXRST 1
`define FSU_FCR_TXRST 2
// Event bits of status, mask and enable registers
`define FSU_EV_RX 0
`define FSU_EV_TX 1
`define FSU_EV_LS 2
`define FSU_EV_MS 3
// Reset values
`define FSU_LCR_RST 8'h03
`define FSU_DIV_RST 16'h0001
// FIFO depth and sixteen-times oversampling counts
`define FSU_FIFO_DEPTH 7'h40
`define FSU_OVS_LAST 5'h0F
`define FSU_OVS_MID 5'h07
`define FSU_STOP15_LAST 5'h17
`define FSU_STOP2_LAST 5'h1F
`define FSU_SIR_PULSE 5'h03
`define FSU_SIR_HOLD 5'h10
// Bus answers
`define FSU_RESP_OK 2'h0
`define FSU_RESP_ERR 2'h2
`endif

// File: core/fsu_pkg.sv
// Types of the serial port core: states, pin groups and state records
package fsu_pkg;
  // Transmitter and receiver sequences
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} fsu_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} fsu_rx_st_t;
  // Modem inputs, active low, ordered like the status nibble
  typedef struct packed {
    logic dcd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } fsu_mdm_in_t;
  // Modem outputs, active low, ordered like the control nibble
  typedef struct packed {
    logic out2_n;
    logic out1_n;
    logic rts_n;
    logic dtr_n;
  } fsu_mdm_out_t;
  // FIFO state
  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [5:0] wp;
    logic [5:0] rp;
    logic [6:0] cnt;
  } fsu_fifo_st_t;
  // Core state
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] wa;
    logic [7:0] wd;
    logic wok;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [3:0] ier;
    logic [7:0] lcr;
    logic [6:0] mcr;
    logic fen;
    logic [1:0] txt;
    logic [1:0] rxt;
    logic [15:0] div;
    logic [7:0] scr;
    logic [3:0] isr;
    logic [3:0] imr;
    logic [3:0] err;
    logic [3:0] msd;
    logic [3:0] mprev;
    logic tx_low;
    logic rx_s1;
    logic rx_s2;
    logic [3:0] md_s1;
    logic [3:0] md_s2;
    logic [15:0] bcnt;
    logic tick;
    fsu_tx_st_t tx_st;
    logic [7:0] tx_sh;
    logic [4:0] tx_cnt;
    logic [2:0] tx_bit;
    logic tx_par;
    logic txd;
    fsu_rx_st_t rx_st;
    logic [7:0] rx_sh;
    logic [4:0] rx_cnt;
    logic [2:0] rx_bit;
    logic rx_par;
    logic [4:0] sir_hold;
  } fsu_st_t;
endpackage : fsu_pkg

// File: core/fsu_top.sv
// Serial port core: bus slave, baud generator, transmitter, receiver, modem and interrupts
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fsu_map.svh"
// What this block does
// R1: CPU bytes serialised onto the transmit pin
// R2: Received characters held until CPU reads
// R3: Software sets length, baud, parity, enables
// R4: One interrupt output, prioritised, separately enabled types
// R5: FIFO mode buffers both directions
// R6: Legacy mode: FIFOs off, single holding byte
// R7: Five to eight bits, parity, 1/1.5/2 stops
// R8: Sixteen-bit programmable baud divisor
// R9: Eight-bit scratch register, no side effects
// R10: Eight modem lines and loop-back mode
// R11: Transmit, receive, modem and line status interrupts
// R12: Optional infrared SIR format, else plain framing
// R13: Both FIFOs hold 64 bytes
// R14: Programmable transmit-empty interrupt trigger
// R15: Low start, LSB first, parity, high stops
// R16: Loop-back feeds receiver, transmit pin idles
// R17: DMA request lines for both directions
module fsu_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial pins
  input wire logic rxd,
  output logic txd,
  // Modem pins
  input wire fsu_pkg::fsu_mdm_in_t mdm_in,
  output fsu_pkg::fsu_mdm_out_t mdm_out,
  // Interrupt and DMA requests
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req
);
  import fsu_pkg::*;
  fsu_st_t st_reg; // All state
  fsu_st_t st_next; // Next state
  logic wr_en; // Register write this cycle
  logic wr_ok; // Low byte lane enabled
  logic [7:0] wr_a; // Write offset
  logic [7:0] wr_d; // Write byte
  logic tx_push, tx_pop, tx_flush, tx_ov; // Transmit FIFO control
  logic rx_push, rx_pop, rx_flush, rx_ov, rx_ir; // Receive FIFO control
  logic [7:0] tx_dout, rx_dout, rxw; // FIFO data and aligned received word
  logic [6:0] tx_fill, rx_fill; // FIFO levels
  logic [3:0] iir_id; // Highest pending interrupt code
  logic rx_trig; // Receive level reached

  // Expected parity bit for a word under the line settings
  function automatic logic fsu_par(input logic [7:0] d, input logic [7:0] lc);
    logic x;
    x = ^(d & (8'hFF >> (2'h3 - lc[1:0])));
    return lc[`FSU_LCR_STK] ? !lc[`FSU_LCR_EPS] : (lc[`FSU_LCR_EPS] ? x : !x);
  endfunction : fsu_par

  // Offset decode shared by reads and writes
  function automatic logic fsu_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `FSU_OFF_IMR);
  endfunction : fsu_mapped

  // Transmit FIFO
  fsu_fifo u_tx_fifo (
    .aclk(aclk), .aresetn(aresetn), .flush(tx_flush), .one_deep(!st_reg.fen),
    .in_valid(tx_push), .in_ready(), .in_data(wr_d),
    .out_valid(tx_ov), .out_ready(tx_pop), .out_data(tx_dout), .level(tx_fill)
  );

  // Receive FIFO
  fsu_fifo u_rx_fifo (
    .aclk(aclk), .aresetn(aresetn), .flush(rx_flush), .one_deep(!st_reg.fen),
    .in_valid(rx_push), .in_ready(rx_ir), .in_data(rxw),
    .out_valid(rx_ov), .out_ready(rx_pop), .out_data(rx_dout), .level(rx_fill)
  );

  // Bus outputs straight from state
  assign awready = !st_reg.aw_got && !st_reg.bvalid;
  assign wready = !st_reg.w_got && !st_reg.bvalid;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = !st_reg.rvalid;
  assign rvalid = st_reg.rvalid;
  assign rresp = st_reg.rresp;
  assign rdata = {24'h000000, st_reg.rdata};
  // Pins, interrupt and DMA
  assign txd = st_reg.txd;
  assign mdm_out = st_reg.mcr[`FSU_MCR_LOOP] ? 4'hF : ~st_reg.mcr[3:0]; // [R10] [R16]
  assign irq = |(st_reg.isr & st_reg.imr); // [R4]
  assign tx_dma_req = st_reg.tx_low; // [R17]
  assign rx_dma_req = rx_trig; // [R17]

  // Next-state logic of the whole core
  always_comb begin
    logic ahs, whs, arh, lpbk, sir, line, tbit, txlow;
    logic [3:0] mst, dm, ev, nerr;
    logic [4:0] stop_last;
    logic [7:0] rv;
    st_next = st_reg;
    ahs = awvalid && awready;
    whs = wvalid && wready;
    arh = arvalid && arready;
    lpbk = st_reg.mcr[`FSU_MCR_LOOP];
    sir = st_reg.mcr[`FSU_MCR_SIR];
    wr_en = (st_reg.aw_got || ahs) && (st_reg.w_got || whs);
    wr_a = ahs ? awaddr[7:0] : st_reg.wa;
    wr_d = whs ? wdata[7:0] : st_reg.wd;
    wr_ok = whs ? wstrb[0] : st_reg.wok;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_flush = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    rx_flush = 1'b0;
    rxw = st_reg.rx_sh >> (2'h3 - st_reg.lcr[1:0]);
    nerr = 4'h0;
    ev = 4'h0;
    rv = 8'h00;
    line = 1'b1;
    // Modem status, looped from the control bits in loop-back
    mst = lpbk ? {st_reg.mcr[3], st_reg.mcr[2], st_reg.mcr[0], st_reg.mcr[1]}
               : ~st_reg.md_s2; // [R10]
    // Pending interrupt code, line status first
    if (st_reg.isr[`FSU_EV_LS] && st_reg.imr[`FSU_EV_LS]) begin
      iir_id = 4'h6; // [R4]
    end else if (st_reg.isr[`FSU_EV_RX] && st_reg.imr[`FSU_EV_RX]) begin
      iir_id = 4'h4;
    end else if (st_reg.isr[`FSU_EV_TX] && st_reg.imr[`FSU_EV_TX]) begin
      iir_id = 4'h2;
    end else if (st_reg.isr[`FSU_EV_MS] && st_reg.imr[`FSU_EV_MS]) begin
      iir_id = 4'h0;
    end else begin
      iir_id = 4'h1;
    end
    // Receive trigger: 1, 16, 32 or 62 bytes, or one byte in legacy mode
    case (st_reg.rxt)
      2'h0: rx_trig = rx_fill >= 7'h01;
      2'h1: rx_trig = rx_fill >= 7'h10;
      2'h2: rx_trig = rx_fill >= 7'h20;
      default: rx_trig = rx_fill >= 7'h3E;
    endcase
    if (!st_reg.fen) begin
      rx_trig = rx_ov; // [R6]
    end
    // Transmit-empty trigger: empty, 2, 16 or 32 bytes left
    case (st_reg.fen ? st_reg.txt : 2'h0)
      2'h0: txlow = tx_fill == 7'h00; // [R14]
      2'h1: txlow = tx_fill <= 7'h02;
      2'h2: txlow = tx_fill <= 7'h10;
      default: txlow = tx_fill <= 7'h20;
    endcase
    // Capture write address and data in either order
    if (ahs) begin
      st_next.aw_got = 1'b1;
      st_next.wa = awaddr[7:0];
    end
    if (whs) begin
      st_next.w_got = 1'b1;
      st_next.wd = wdata[7:0];
      st_next.wok = wstrb[0];
    end
    if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end
    // Register write once both halves are in
    if (wr_en) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = fsu_mapped(wr_a) ? `FSU_RESP_OK : `FSU_RESP_ERR;
      if (!wr_ok) begin
        // Low lane disabled: nothing stored
      end else if (wr_a == `FSU_OFF_DATA) begin
        if (st_reg.lcr[`FSU_LCR_DLAB]) begin
          st_next.div[7:0] = wr_d; // [R8]
        end else begin
          tx_push = 1'b1; // [R1]
        end
      end else if (wr_a == `FSU_OFF_IER) begin
        if (st_reg.lcr[`FSU_LCR_DLAB]) begin
          st_next.div[15:8] = wr_d; // [R8]
        end else begin
          st_next.ier = wr_d[3:0]; // [R3]
        end
      end else if (wr_a == `FSU_OFF_IIR) begin
        st_next.fen = wr_d[`FSU_FCR_EN]; // [R5] [R6]
        st_next.txt = wr_d[5:4]; // [R14]
        st_next.rxt = wr_d[7:6];
        rx_flush = wr_d[`FSU_FCR_RXRST] || (wr_d[`FSU_FCR_EN] != st_reg.fen);
        tx_flush = wr_d[`FSU_FCR_TXRST] || (wr_d[`FSU_FCR_EN] != st_reg.fen);
      end else if (wr_a == `FSU_OFF_LCR) begin
        st_next.lcr = wr_d; // [R3] [R7]
      end else if (wr_a == `FSU_OFF_MCR) begin
        st_next.mcr = wr_d[6:0]; // [R10] [R12]
      end else if (wr_a == `FSU_OFF_SCR) begin
        st_next.scr = wr_d; // [R9]
      end else if (wr_a == `FSU_OFF_ISR) begin
        st_next.isr = st_reg.isr & ~wr_d[3:0];
      end else if (wr_a == `FSU_OFF_IMR) begin
        st_next.imr = wr_d[3:0];
      end
    end
    // Register read; answer one cycle after the address is taken
    if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    if (arh) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = fsu_mapped(araddr[7:0]) ? `FSU_RESP_OK : `FSU_RESP_ERR;
      if (araddr[7:0] == `FSU_OFF_DATA) begin
        rv = st_reg.lcr[`FSU_LCR_DLAB] ? st_reg.div[7:0] : rx_dout;
        rx_pop = !st_reg.lcr[`FSU_LCR_DLAB] && rx_ov; // [R2]
      end else if (araddr[7:0] == `FSU_OFF_IER) begin
        rv = st_reg.lcr[`FSU_LCR_DLAB] ? st_reg.div[15:8] : {4'h0, st_reg.ier};
      end else if (araddr[7:0] == `FSU_OFF_IIR) begin
        rv = {st_reg.fen, st_reg.fen, 2'h0, iir_id}; // [R4]
      end else if (araddr[7:0] == `FSU_OFF_LCR) begin
        rv = st_reg.lcr;
      end else if (araddr[7:0] == `FSU_OFF_MCR) begin
        rv = {1'b0, st_reg.mcr};
      end else if (araddr[7:0] == `FSU_OFF_LSR) begin
        rv = {st_reg.fen && (|st_reg.err), (tx_fill == 7'h00) && (st_reg.tx_st == TX_IDLE),
              tx_fill == 7'h00, st_reg.err, rx_ov};
        st_next.err = 4'h0;
      end else if (araddr[7:0] == `FSU_OFF_MSR) begin
        rv = {mst, st_reg.msd};
        st_next.msd = 4'h0;
      end else if (araddr[7:0] == `FSU_OFF_SCR) begin
        rv = st_reg.scr; // [R9]
      end else if (araddr[7:0] == `FSU_OFF_ISR) begin
        rv = {4'h0, st_reg.isr};
      end else if (araddr[7:0] == `FSU_OFF_IMR) begin
        rv = {4'h0, st_reg.imr};
      end
      st_next.rdata = rv;
    end
    // Pin synchronisers
    st_next.rx_s1 = rxd;
    st_next.rx_s2 = st_reg.rx_s1;
    st_next.md_s1 = mdm_in;
    st_next.md_s2 = st_reg.md_s1;
    // Modem deltas; ring counts on its trailing edge
    dm = {st_reg.mprev[3] ^ mst[3], st_reg.mprev[2] && !mst[2],
          st_reg.mprev[1] ^ mst[1], st_reg.mprev[0] ^ mst[0]};
    st_next.msd = st_next.msd | dm;
    st_next.mprev = mst;
    // Baud generator: one tick per sixteenth of a bit
    st_next.tick = st_reg.bcnt == 16'h0000;
    if (st_reg.bcnt == 16'h0000) begin
      st_next.bcnt = (st_reg.div == 16'h0000) ? 16'h0000 : st_reg.div - 16'h0001; // [R8]
    end else begin
      st_next.bcnt = st_reg.bcnt - 16'h0001;
    end
    // Current transmit bit value
    case (st_reg.tx_st)
      TX_START: tbit = 1'b0; // [R15]
      TX_DATA: tbit = st_reg.tx_sh[0];
      TX_PAR: tbit = st_reg.tx_par;
      default: tbit = 1'b1;
    endcase
    // Transmit pin: idle in loop-back, short pulse per zero in SIR
    if (lpbk) begin
      st_next.txd = 1'b1; // [R16]
    end else if (sir) begin
      st_next.txd = !tbit && (st_reg.tx_cnt < `FSU_SIR_PULSE); // [R12]
    end else begin
      st_next.txd = tbit && !st_reg.lcr[`FSU_LCR_BRK]; // [R12]
    end
    // Infrared receive pulses stretched over a bit
    if (st_reg.rx_s2) begin
      st_next.sir_hold = `FSU_SIR_HOLD;
    end else if (st_reg.tick && (st_reg.sir_hold != 5'h00)) begin
      st_next.sir_hold = st_reg.sir_hold - 5'h01;
    end
    if (lpbk) begin
      line = tbit; // [R16]
    end else if (sir) begin
      line = !st_reg.rx_s2 && (st_reg.sir_hold == 5'h00); // [R12]
    end else begin
      line = st_reg.rx_s2;
    end
    // Stop length: 1, 1.5 with five bits, else 2
    if (!st_reg.lcr[`FSU_LCR_STB]) begin
      stop_last = `FSU_OVS_LAST;
    end else if (st_reg.lcr[1:0] == 2'h0) begin
      stop_last = `FSU_STOP15_LAST; // [R7]
    end else begin
      stop_last = `FSU_STOP2_LAST; // [R7]
    end
    if (st_reg.tick) begin
      // Transmitter
      st_next.tx_cnt = st_reg.tx_cnt + 5'h01;
      case (st_reg.tx_st)
        TX_IDLE: begin
          st_next.tx_cnt = 5'h00;
          if (tx_ov && (!st_reg.mcr[`FSU_MCR_AFC] || mst[0])) begin
            tx_pop = 1'b1; // [R1]
            st_next.tx_sh = tx_dout;
            st_next.tx_par = fsu_par(tx_dout, st_reg.lcr); // [R3]
            st_next.tx_bit = 3'h0;
            st_next.tx_st = TX_START;
          end
        end
        TX_START: begin
          if (st_reg.tx_cnt == `FSU_OVS_LAST) begin
            st_next.tx_cnt = 5'h00;
            st_next.tx_st = TX_DATA;
          end
        end
        TX_DATA: begin
          if (st_reg.tx_cnt == `FSU_OVS_LAST) begin
            st_next.tx_cnt = 5'h00;
            st_next.tx_sh = st_reg.tx_sh >> 1; // [R15]
            st_next.tx_bit = st_reg.tx_bit + 3'h1;
            if (st_reg.tx_bit == {1'b1, st_reg.lcr[1:0]}) begin
              st_next.tx_st = st_reg.lcr[`FSU_LCR_PEN] ? TX_PAR : TX_STOP; // [R7]
            end
          end
        end
        TX_PAR: begin
          if (st_reg.tx_cnt == `FSU_OVS_LAST) begin
            st_next.tx_cnt = 5'h00;
            st_next.tx_st = TX_STOP;
          end
        end
        default: begin
          if (st_reg.tx_cnt == stop_last) begin
            st_next.tx_st = TX_IDLE;
          end
        end
      endcase
      // Receiver, sampling mid-bit
      st_next.rx_cnt = st_reg.rx_cnt + 5'h01;
      case (st_reg.rx_st)
        RX_IDLE: begin
          st_next.rx_cnt = 5'h00;
          if (!line) begin
            st_next.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (st_reg.rx_cnt == `FSU_OVS_MID) begin
            st_next.rx_cnt = 5'h00;
            st_next.rx_bit = 3'h0;
            st_next.rx_st = line ? RX_IDLE : RX_DATA; // [R15]
          end
        end
        RX_DATA: begin
          if (st_reg.rx_cnt == `FSU_OVS_LAST) begin
            st_next.rx_cnt = 5'h00;
            st_next.rx_sh = {line, st_reg.rx_sh[7:1]}; // [R15]
            st_next.rx_bit = st_reg.rx_bit + 3'h1;
            if (st_reg.rx_bit == {1'b1, st_reg.lcr[1:0]}) begin
              st_next.rx_st = st_reg.lcr[`FSU_LCR_PEN] ? RX_PAR : RX_STOP; // [R7]
            end
          end
        end
        RX_PAR: begin
          if (st_reg.rx_cnt == `FSU_OVS_LAST) begin
            st_next.rx_cnt = 5'h00;
            st_next.rx_par = line;
            st_next.rx_st = RX_STOP;
          end
        end
        default: begin
          if (st_reg.rx_cnt == `FSU_OVS_LAST) begin
            st_next.rx_st = RX_IDLE;
            rx_push = 1'b1; // [R2]
            nerr[0] = !rx_ir;
            nerr[1] = st_reg.lcr[`FSU_LCR_PEN] && (st_reg.rx_par != fsu_par(rxw, st_reg.lcr));
            nerr[2] = !line;
            nerr[3] = !line && (rxw == 8'h00) && !(st_reg.lcr[`FSU_LCR_PEN] && st_reg.rx_par);
          end
        end
      endcase
    end
    // Sticky events; a new event beats a clear in the same cycle
    st_next.err = st_next.err | nerr;
    st_next.tx_low = txlow;
    ev[`FSU_EV_RX] = rx_trig; // [R11]
    ev[`FSU_EV_TX] = txlow && !st_reg.tx_low; // [R11] [R14]
    ev[`FSU_EV_LS] = |nerr; // [R11]
    ev[`FSU_EV_MS] = |dm; // [R11]
    st_next.isr = st_next.isr | (ev & st_reg.ier); // [R3] [R4]
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.lcr <= `FSU_LCR_RST;
      st_reg.div <= `FSU_DIV_RST;
      st_reg.txd <= 1'b1;
      st_reg.tx_low <= 1'b1;
      st_reg.rx_s1 <= 1'b1;
      st_reg.rx_s2 <= 1'b1;
      st_reg.md_s1 <= 4'hF;
      st_reg.md_s2 <= 4'hF;
    end else begin
      st_reg <= st_next;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_LOOP_IDLE: assert property ( // [R16]
    $past(st_reg.mcr[`FSU_MCR_LOOP]) |-> txd) else $error("transmit pin active in loop-back");
  AST_START_LOW: assert property ( // [R15]
    st_reg.tx_st == TX_START && st_reg.mcr[6:4] == 3'h0 && !st_reg.lcr[`FSU_LCR_BRK] |=> !txd)
    else $error("start bit not low");
  AST_START_LEN: assert property ( // [R15]
    $rose(st_reg.tx_st == TX_START) |-> (st_reg.tx_st == TX_START)[*8])
    else $error("start bit too short");
  AST_DIVISOR: assert property ( // [R8]
    st_reg.bcnt == 16'h0000 && st_reg.div > 16'h0001 |=> st_reg.bcnt == $past(st_reg.div) - 16'h0001)
    else $error("baud counter reload wrong");
  AST_SCRATCH: assert property ( // [R9]
    wr_en && wr_ok && wr_a == `FSU_OFF_SCR |=> st_reg.scr == $past(wr_d))
    else $error("scratch write lost");
  AST_OVERRUN: assert property ( // [R2]
    rx_push && !rx_ir |=> st_reg.err[0]) else $error("overrun not flagged");
  AST_LEGACY: assert property ( // [R6]
    !st_reg.fen |-> rx_fill <= 7'h01 && tx_fill <= 7'h01) else $error("legacy mode holds >1 byte");
  AST_DEPTH: assert property ( // [R13]
    rx_fill <= `FSU_FIFO_DEPTH && tx_fill <= `FSU_FIFO_DEPTH) else $error("FIFO above 64");
  AST_IRQ_LS: assert property ( // [R4]
    st_reg.isr[`FSU_EV_LS] && st_reg.imr[`FSU_EV_LS] |-> irq && iir_id == 4'h6)
    else $error("line status interrupt not top");
  AST_IER_GATE: assert property ( // [R3]
    !st_reg.ier[`FSU_EV_MS] && !st_reg.isr[`FSU_EV_MS] |=> !st_reg.isr[`FSU_EV_MS])
    else $error("disabled source set status");
endmodule : fsu_top

// File: testbench/fsu_peer.sv
// Serial line partner: sends and captures characters at 16 cycles a bit
`timescale 1ns/1ps
module fsu_peer (
  // Clock
  input wire logic aclk,
  // Line
  input wire logic txd,
  output logic rxd,
  // Control and capture
  input wire logic send,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic [7:0] rx_cnt
);
  initial begin
    rxd = 1'b1;
    rx_cnt = 8'h00;
    rx_byte = 8'h00;
  end
  // Start low, data LSB first, stop high, then idle high
  always @(posedge aclk) if (send) begin
    for (int i = -1; i < 9; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : tx_byte[i];
      repeat (16) @(posedge aclk);
    end
  end
  // Samples each bit mid-period; counts only frames with a high stop
  always begin
    @(negedge txd);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge aclk);
      rx_byte[i] = txd;
    end
    repeat (16) @(posedge aclk);
    if (txd) rx_cnt = rx_cnt + 8'h01;
  end
endmodule : fsu_peer

// File: testbench/test_fsu_top.sv
// Testbench of the serial port core: registers, transmit, receive, interrupt
`timescale 1ns/1ps
`include "fsu_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t got %h expected %h", $time, g, e); end end
module test_fsu_top;
  import fsu_pkg::*;
  // Clock, reset and bus drives
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, send = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [7:0] tx_byte = 8'h00, peer_byte, peer_cnt;
  logic [3:0] mdm_i = 4'hF, mdm_o;
  logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq, rx_dma_req, tx_dma_req;
  logic [1:0] bresp, rresp;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  always #2.5 aclk = ~aclk;
  fsu_top fsu_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .rxd(rxd), .txd(txd), .mdm_in(mdm_i), .mdm_out(mdm_o), .irq(irq),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));
  fsu_peer fsu_peer_inst (.aclk(aclk), .txd(txd), .rxd(rxd), .send(send),
    .tx_byte(tx_byte), .rx_byte(peer_byte), .rx_cnt(peer_cnt));
  // Prints the verdict and ends the run
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  // Write: both halves offered, each released once taken, waits for the answer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    logic [1:0] rb;
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rb = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    `CHK(rb, `FSU_RESP_OK)
    @(negedge aclk);
  endtask : wr
  // Read and compare data and response
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] re);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    `CHK(d, {24'h000000, e})
    `CHK(r, re)
  endtask : chk_rd
  // Reset value, scratch round trip, unmapped place
  task automatic t_regs;
    chk_rd(`FSU_OFF_LCR, `FSU_LCR_RST, `FSU_RESP_OK);
    wr(`FSU_OFF_SCR, 8'h5A);
    chk_rd(`FSU_OFF_SCR, 8'h5A, `FSU_RESP_OK);
    chk_rd(8'h28, 8'h00, `FSU_RESP_ERR);
  endtask : t_regs
  // Modem lines out, status in, then one character through loop-back
  task automatic t_mdm;
    int n = 0;
    wr(`FSU_OFF_MCR, 8'h03);
    `CHK(mdm_o, 4'hC)
    @(posedge aclk);
    mdm_i <= 4'hE;
    repeat (4) @(posedge aclk);
    chk_rd(`FSU_OFF_MSR, 8'h11, `FSU_RESP_OK);
    wr(`FSU_OFF_MCR, 8'h13);
    `CHK(mdm_o, 4'hF)
    chk_rd(`FSU_OFF_MSR, 8'h32, `FSU_RESP_OK);
    wr(`FSU_OFF_DATA, 8'h96);
    while (!rx_dma_req && n < 1000) begin
      @(negedge aclk);
      n++;
    end
    chk_rd(`FSU_OFF_DATA, 8'h96, `FSU_RESP_OK);
    `CHK(peer_cnt, 8'h00)
    wr(`FSU_OFF_MCR, 8'h00);
  endtask : t_mdm
  // One byte out on the line, checked by the partner
  task automatic t_tx;
    int n = 0;
    wr(`FSU_OFF_DATA, 8'hA5);
    `CHK(tx_dma_req, 1'b0)
    while (peer_cnt !== 8'h01 && n < 1000) begin
      @(negedge aclk);
      n++;
    end
    `CHK(peer_byte, 8'hA5)
    `CHK(txd, 1'b1)
    `CHK(tx_dma_req, 1'b1)
  endtask : t_tx
  // One byte in: request, masked then unmasked interrupt, read, clear
  task automatic t_rx;
    int n = 0;
    wr(`FSU_OFF_IER, 8'h01);
    @(posedge aclk);
    tx_byte <= 8'h3C;
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    while (!rx_dma_req && n < 1000) begin
      @(negedge aclk);
      n++;
    end
    `CHK(rx_dma_req, 1'b1)
    `CHK(irq, 1'b0)
    wr(`FSU_OFF_IMR, 8'h01);
    `CHK(irq, 1'b1)
    chk_rd(`FSU_OFF_IIR, 8'h04, `FSU_RESP_OK);
    chk_rd(`FSU_OFF_DATA, 8'h3C, `FSU_RESP_OK);
    wr(`FSU_OFF_ISR, 8'h01);
    `CHK(irq, 1'b0)
  endtask : t_rx
  // Cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_mdm();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule : test_fsu_top
